// >>> design/mcr_mode_config_three.sv
// Third mode configuration register with its hold-pin error trigger and debug event
`default_nettype none

module mcr_mode_config_three
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire mcr_pkg::mcr_apb_req_t apb_req,
    output var  mcr_pkg::mcr_apb_rsp_t apb_rsp,
    output var  mcr_pkg::mcr_mode_t    mode_cfg,
    input  wire logic                  seq_cmd_hit,
    input  wire logic                  rx_error,
    input  wire logic                  legacy_hold_token,
    input  wire logic                  tx_active,
    input  wire logic                  tx_data,
    input  wire logic                  transmit_line_pin,
    input  wire logic                  receive_line_pin,
    output var  logic                  hold_grant_output_pin,
    output var  logic                  write_violation_irq,
    output var  logic                  irq
);
    import mcr_pkg::*;

    mcr_state_t cur_reg;
    mcr_state_t state_next;

    function automatic logic addr_is(input logic [15:0] addr, input logic [15:0] target);
        addr_is = (addr == target);
    endfunction : addr_is

    function automatic logic addr_mapped(input logic [15:0] addr);
        addr_mapped = addr_is(addr, MODE3_ADDR) || addr_is(addr, STATUS_ADDR)
                      || addr_is(addr, MASK_ADDR);
    endfunction : addr_mapped

    logic               mism_tx;
    logic               mism_rx;
    logic               send_err;
    logic [EVENT_W-1:0] events;
    logic [EVENT_W-1:0] clr_mask;
    logic               wr_take;

    always_comb
    begin
        state_next = cur_reg;
        mism_tx    = 1'b0;
        mism_rx    = 1'b0;
        send_err   = 1'b0;
        events     = '0;
        clr_mask   = '0;
        wr_take    = 1'b0;
        if (ce)
        begin
            // Pins cross in through two flops; sent data is delayed to match
            state_next.txd_sync   = {cur_reg.txd_sync[0], transmit_line_pin};
            state_next.rxd_sync   = {cur_reg.rxd_sync[0], receive_line_pin};
            state_next.tx_dly     = {cur_reg.tx_dly[0], tx_data};
            state_next.tx_act_dly = {cur_reg.tx_act_dly[0], tx_active};

            mism_tx = cur_reg.tx_act_dly[1]
                      && (cur_reg.txd_sync[1] != cur_reg.tx_dly[1]);
            mism_rx = cur_reg.tx_act_dly[1]
                      && (cur_reg.rxd_sync[1]
                          != (cur_reg.tx_dly[1] ^ cur_reg.mode.rx_echo_inverted));

            unique case (cur_reg.mode.hold_func)
                HF_LEGACY:
                begin
                    state_next.hold_pin = legacy_hold_token;
                end
                HF_RX_ERR:
                begin
                    state_next.hold_pin = rx_error;
                end
                HF_TX_CMP:
                begin
                    send_err            = mism_tx;
                    state_next.hold_pin = mism_tx;
                end
                HF_RX_CMP:
                begin
                    send_err            = mism_rx;
                    state_next.hold_pin = mism_rx;
                end
            endcase

            state_next.wv_pulse = cur_reg.mode.debug_irq_en && seq_cmd_hit;
            events[EV_DEBUG]    = state_next.wv_pulse;
            events[EV_RX_ERR]   = rx_error;
            events[EV_SEND_ERR] = send_err;

            // Registered answer: pready is loaded at the setup edge, so there is no wait state and every output is on a flop
            unique case (cur_reg.apb_st)
                AP_IDLE:
                begin
                    if (apb_req.psel && !apb_req.penable)
                    begin
                        state_next.apb_st      = AP_ACK;
                        state_next.rsp.pready  = 1'b1;
                        state_next.rsp.pslverr = !addr_mapped(apb_req.paddr);
                        state_next.rsp.prdata  = '0;
                        if (!apb_req.pwrite && addr_is(apb_req.paddr, STATUS_ADDR))
                        begin
                            state_next.rsp.prdata[EVENT_W-1:0] = cur_reg.status;
                        end
                        if (!apb_req.pwrite && addr_is(apb_req.paddr, MASK_ADDR))
                        begin
                            state_next.rsp.prdata[EVENT_W-1:0] = cur_reg.mask;
                        end
                    end
                end
                AP_ACK:
                begin
                    if (apb_req.psel && apb_req.penable)
                    begin
                        state_next.apb_st = AP_IDLE;
                        state_next.rsp    = RSP_IDLE;
                        wr_take           = apb_req.pwrite;
                    end
                end
            endcase

            // Reads fall through here untouched, so they cannot disturb settings
            if (wr_take && addr_is(apb_req.paddr, MODE3_ADDR))
            begin
                state_next.mode = mcr_mode_t'(apb_req.pwdata[MODE_W-1:0]);
            end
            if (wr_take && addr_is(apb_req.paddr, MASK_ADDR))
            begin
                state_next.mask = apb_req.pwdata[EVENT_W-1:0];
            end
            if (wr_take && addr_is(apb_req.paddr, STATUS_ADDR))
            begin
                clr_mask = apb_req.pwdata[EVENT_W-1:0];
            end
            // A new event beats a clear in the same cycle
            state_next.status = (cur_reg.status & ~clr_mask) | events;
            state_next.irq    = |(state_next.status & state_next.mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_reg <= STATE_RST;
        end
        else
        begin
            cur_reg <= state_next;
        end
    end

    assign apb_rsp               = cur_reg.rsp;
    assign mode_cfg              = cur_reg.mode;
    assign hold_grant_output_pin = cur_reg.hold_pin;
    assign write_violation_irq   = cur_reg.wv_pulse;
    assign irq                   = cur_reg.irq;

    property p_mode_write;
        @(posedge pclk) disable iff (!presetn)
        (ce && cur_reg.apb_st == AP_ACK && apb_req.psel && apb_req.penable
         && apb_req.pwrite && apb_req.paddr == MODE3_ADDR)
        |=> (mode_cfg == mcr_mode_t'($past(apb_req.pwdata[MODE_W-1:0])));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode register write not stored");

    property p_mode_read_zero;
        @(posedge pclk) disable iff (!presetn)
        (ce && cur_reg.apb_st == AP_IDLE && apb_req.psel && !apb_req.penable
         && !apb_req.pwrite && apb_req.paddr == MODE3_ADDR)
        |=> (apb_rsp.pready && apb_rsp.prdata == '0 && !apb_rsp.pslverr);
    endproperty
    a_mode_read_zero: assert property (p_mode_read_zero)
        else $error("write-only register returned data");

    property p_read_no_change;
        @(posedge pclk) disable iff (!presetn)
        (apb_req.psel && !apb_req.pwrite) ##1 (apb_req.psel && !apb_req.pwrite)
        |=> $stable(mode_cfg);
    endproperty
    a_read_no_change: assert property (p_read_no_change)
        else $error("read changed the mode register");

    property p_reset_values;
        @(posedge pclk)
        $rose(presetn) |-> (mode_cfg == MODE3_RST && !hold_grant_output_pin);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("mode register not cleared by reset");

    property p_debug_fires;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.debug_irq_en && seq_cmd_hit)
        |=> (write_violation_irq && cur_reg.status[EV_DEBUG]);
    endproperty
    a_debug_fires: assert property (p_debug_fires)
        else $error("debug command did not raise write violation");

    property p_debug_quiet;
        @(posedge pclk) disable iff (!presetn)
        (ce && !mode_cfg.debug_irq_en) |=> !write_violation_irq;
    endproperty
    a_debug_quiet: assert property (p_debug_quiet)
        else $error("write violation raised while disabled");

    property p_legacy_pin;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_LEGACY)
        |=> (hold_grant_output_pin == $past(legacy_hold_token));
    endproperty
    a_legacy_pin: assert property (p_legacy_pin)
        else $error("legacy hold token not passed through");

    property p_rx_err_pulse;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_RX_ERR)
        |=> (hold_grant_output_pin == $past(rx_error));
    endproperty
    a_rx_err_pulse: assert property (p_rx_err_pulse)
        else $error("hold pin does not follow receive error");

    property p_tx_match;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_TX_CMP && cur_reg.tx_act_dly[1]
         && cur_reg.txd_sync[1] == cur_reg.tx_dly[1])
        |=> !hold_grant_output_pin;
    endproperty
    a_tx_match: assert property (p_tx_match)
        else $error("matching transmit pin flagged as send error");

    // Nothing is compared while the delayed transmit-active flag is low
    property p_tx_idle;
        @(posedge pclk) disable iff (!presetn)
        (ce && (mode_cfg.hold_func == HF_TX_CMP || mode_cfg.hold_func == HF_RX_CMP)
         && !cur_reg.tx_act_dly[1])
        |=> !hold_grant_output_pin;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("send error flagged while not transmitting");

    property p_tx_mismatch;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_TX_CMP && cur_reg.tx_act_dly[1]
         && cur_reg.txd_sync[1] != cur_reg.tx_dly[1])
        |=> (hold_grant_output_pin && cur_reg.status[EV_SEND_ERR]);
    endproperty
    a_tx_mismatch: assert property (p_tx_mismatch)
        else $error("transmit pin mismatch not flagged");

    property p_rx_match;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_RX_CMP && cur_reg.tx_act_dly[1]
         && cur_reg.rxd_sync[1] == (cur_reg.tx_dly[1] ^ mode_cfg.rx_echo_inverted))
        |=> !hold_grant_output_pin;
    endproperty
    a_rx_match: assert property (p_rx_match)
        else $error("matching echo flagged as send error");

    property p_rx_mismatch;
        @(posedge pclk) disable iff (!presetn)
        (ce && mode_cfg.hold_func == HF_RX_CMP && cur_reg.tx_act_dly[1]
         && cur_reg.rxd_sync[1] != (cur_reg.tx_dly[1] ^ mode_cfg.rx_echo_inverted))
        |=> hold_grant_output_pin;
    endproperty
    a_rx_mismatch: assert property (p_rx_mismatch)
        else $error("receive pin mismatch not flagged");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        irq == |(cur_reg.status & cur_reg.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status and mask");

    property p_status_sticky;
        @(posedge pclk) disable iff (!presetn)
        (cur_reg.status[EV_RX_ERR]
         && !(ce && cur_reg.apb_st == AP_ACK && apb_req.psel && apb_req.penable
              && apb_req.pwrite && apb_req.paddr == STATUS_ADDR
              && apb_req.pwdata[EV_RX_ERR]))
        |=> cur_reg.status[EV_RX_ERR];
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("receive error status lost without a clear");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (ce && rx_error) |=> cur_reg.status[EV_RX_ERR];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("receive error not recorded in status");

    property p_w1c_clear;
        @(posedge pclk) disable iff (!presetn)
        (ce && cur_reg.apb_st == AP_ACK && apb_req.psel && apb_req.penable
         && apb_req.pwrite && apb_req.paddr == STATUS_ADDR
         && apb_req.pwdata[EV_RX_ERR] && !rx_error)
        |=> !cur_reg.status[EV_RX_ERR];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("write of one did not clear receive error status");

    // Modes 00 and 01 must never raise the send error flag
    property p_send_err_quiet;
        @(posedge pclk) disable iff (!presetn)
        (ce && !cur_reg.status[EV_SEND_ERR]
         && (mode_cfg.hold_func == HF_LEGACY || mode_cfg.hold_func == HF_RX_ERR))
        |=> !cur_reg.status[EV_SEND_ERR];
    endproperty
    a_send_err_quiet: assert property (p_send_err_quiet)
        else $error("send error flagged outside the compare modes");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        (ce && cur_reg.apb_st == AP_IDLE && apb_req.psel && !apb_req.penable
         && apb_req.paddr != MODE3_ADDR && apb_req.paddr != STATUS_ADDR
         && apb_req.paddr != MASK_ADDR)
        |=> (apb_rsp.pready && apb_rsp.pslverr);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped address answered without error");

    property p_pready_once;
        @(posedge pclk) disable iff (!presetn)
        (ce && apb_rsp.pready && apb_req.psel && apb_req.penable) |=> !apb_rsp.pready;
    endproperty
    a_pready_once: assert property (p_pready_once)
        else $error("bus answer stood longer than one access cycle");

    // A low enable freezes every stored bit, bus answer included
    property p_ce_freeze;
        @(posedge pclk) disable iff (!presetn)
        !ce |=> ($stable(mode_cfg) && $stable(apb_rsp) && $stable(irq)
                 && $stable(hold_grant_output_pin));
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while the clock enable was low");

endmodule : mcr_mode_config_three

`default_nettype wire

// >>> pkg/mcr_pkg.sv
// Package for the third mode configuration register block: map, fields, carriers
`default_nettype none

package mcr_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [15:0] MODE3_IDX    = 16'h031B;
    localparam logic [15:0] STATUS_IDX   = 16'h0320;
    localparam logic [15:0] MASK_IDX     = 16'h0321;
    localparam int          ADDR_SHIFT   = 2;
    localparam logic [15:0] MODE3_ADDR   = MODE3_IDX << ADDR_SHIFT;
    localparam logic [15:0] STATUS_ADDR  = STATUS_IDX << ADDR_SHIFT;
    localparam logic [15:0] MASK_ADDR    = MASK_IDX << ADDR_SHIFT;

    localparam int          MODE_W       = 8;
    localparam int          EVENT_W      = 3;

    // Event bit positions in the status and mask registers
    localparam int          EV_DEBUG     = 0;
    localparam int          EV_RX_ERR    = 1;
    localparam int          EV_SEND_ERR  = 2;

    // Function of the hold-grant output pin
    typedef enum logic [1:0] {
        HF_LEGACY  = 2'h0,
        HF_RX_ERR  = 2'h1,
        HF_TX_CMP  = 2'h2,
        HF_RX_CMP  = 2'h3
    } mcr_hold_func_t;

    // Field layout of mode_config_three, bit 7 down to bit 0
    typedef struct packed {
        logic           alternate_fieldbus_mode;
        logic           rx_echo_inverted;
        mcr_hold_func_t hold_func;
        logic           wide_segment_select;
        logic           quick_sync_new;
        logic           debug_irq_en;
        logic           pulse_mod_en;
    } mcr_mode_t;

    localparam mcr_mode_t MODE3_RST = '{default: 1'b0, hold_func: HF_LEGACY};

    // Bus handshake states, Gray coded
    typedef enum logic [0:0] {
        AP_IDLE = 1'b0,
        AP_ACK  = 1'b1
    } mcr_apb_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } mcr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mcr_apb_rsp_t;

    localparam mcr_apb_rsp_t RSP_IDLE = '{default: '0};

    typedef struct packed {
        mcr_apb_st_t        apb_st;
        mcr_apb_rsp_t       rsp;
        mcr_mode_t          mode;
        logic [EVENT_W-1:0] status;
        logic [EVENT_W-1:0] mask;
        logic               irq;
        logic               hold_pin;
        logic               wv_pulse;
        logic [1:0]         txd_sync;
        logic [1:0]         rxd_sync;
        logic [1:0]         tx_dly;
        logic [1:0]         tx_act_dly;
    } mcr_state_t;

    localparam mcr_state_t STATE_RST = '{apb_st: AP_IDLE, rsp: RSP_IDLE,
                                         mode: MODE3_RST, default: '0};

endpackage : mcr_pkg

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the third mode configuration register block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mcr_pkg::*;

    logic         pclk;
    logic         presetn;
    logic         ce;
    mcr_apb_req_t req;
    mcr_apb_rsp_t rsp;
    mcr_mode_t    mode_cfg;
    logic [1:0]   ev;
    logic         legacy;
    logic         tx_act;
    logic         tx_dat;
    logic         tpin;
    logic         rpin;
    logic         hold_pin;
    logic         wv_irq;
    logic         irq;
    int           fail_count;
    int           cmp_count;
    int           seen;
    logic [31:0]  rd;
    logic         err;
    // Row: mode byte, 4'b0, tx_active, transmit pin, receive pin, pulse expected
    localparam logic [15:0] CMP_TAB [8] = '{16'h200B, 16'h200C, 16'h2000, 16'h300D,
                                            16'h300A, 16'h700C, 16'h700B, 16'h1008};

    mcr_mode_config_three dut
    (
        .pclk                  (pclk),
        .presetn               (presetn),
        .ce                    (ce),
        .apb_req               (req),
        .apb_rsp               (rsp),
        .mode_cfg              (mode_cfg),
        .seq_cmd_hit           (ev[0]),
        .rx_error              (ev[1]),
        .legacy_hold_token     (legacy),
        .tx_active             (tx_act),
        .tx_data               (tx_dat),
        .transmit_line_pin     (tpin),
        .receive_line_pin      (rpin),
        .hold_grant_output_pin (hold_pin),
        .write_violation_irq   (wv_irq),
        .irq                   (irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
            begin
                fail_count++;
                $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
            end
    endtask : check

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '{default: '0};
        if (rsp.pready !== 1'b1)
            begin
                fail_count++;
                $display("CHECK FAILED at %0t: bus answer timed out", $time);
                stop_test();
            end
        #1;
    endtask : apb

    // One-cycle event pulse; returns just after the edge that registers it
    task automatic pulse(input logic [1:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= 2'h0;
        #1;
    endtask : pulse

    task automatic watch(input int cycles);
        seen = 0;
        repeat (cycles)
        begin
            @(posedge pclk);
            #1;
            if (hold_pin === 1'b1)
                seen++;
        end
    endtask : watch

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        req = '{default: '0};
        {ev, legacy, tx_act, tx_dat, tpin, rpin} = '0;
        fail_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check({24'h0, mode_cfg}, 32'h0, "reset value");
        $display("Test reset done");
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, MODE3_ADDR, 32'hFFFFFF00 | (32'h1 << i));
            check({24'h0, mode_cfg}, 32'h1 << i, "mode bit");
        end
        apb(1'b1, MODE3_ADDR, 32'h0000005A);
        apb(1'b0, MODE3_ADDR, 32'h0);
        check(rd, 32'h0, "mode read back");
        check({24'h0, mode_cfg}, 32'h5A, "mode after read");
        apb(1'b1, 16'h0C70, 32'hFF);
        check({31'h0, err}, 32'h1, "unmapped error");
        check({24'h0, mode_cfg}, 32'h5A, "mode after unmapped");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check({24'h0, mode_cfg}, 32'h0, "mode after second reset");
        $display("Test register done");
        apb(1'b1, MODE3_ADDR, 32'h0);
        @(posedge pclk);
        legacy <= 1'b1;
        pulse(2'h2);
        check({31'h0, hold_pin}, 32'h1, "legacy high");
        @(posedge pclk);
        legacy <= 1'b0;
        @(posedge pclk);
        #1;
        check({31'h0, hold_pin}, 32'h0, "legacy low");
        $display("Test legacy done");
        apb(1'b1, STATUS_ADDR, 32'h7);
        apb(1'b1, MODE3_ADDR, 32'h10);
        pulse(2'h2);
        check({31'h0, hold_pin}, 32'h1, "rx error pulse");
        @(posedge pclk);
        #1;
        check({30'h0, hold_pin, irq}, 32'h0, "pulse end, irq masked");
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'h2, "rx error status");
        apb(1'b1, MASK_ADDR, 32'h2);
        repeat (2) @(posedge pclk);
        #1;
        check({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1'b1, STATUS_ADDR, 32'h2);
        repeat (2) @(posedge pclk);
        #1;
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("Test receive error done");
        apb(1'b1, MODE3_ADDR, 32'h0);
        pulse(2'h1);
        check({31'h0, wv_irq}, 32'h0, "debug disabled");
        apb(1'b1, MODE3_ADDR, 32'h2);
        pulse(2'h1);
        check({31'h0, wv_irq}, 32'h1, "debug pulse");
        @(posedge pclk);
        #1;
        check({31'h0, wv_irq}, 32'h0, "debug pulse end");
        $display("Test debug done");
        @(posedge pclk);
        tx_dat <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, MODE3_ADDR, {24'h0, CMP_TAB[i][15:8]});
            @(posedge pclk);
            {tx_act, tpin, rpin} <= CMP_TAB[i][3:1];
            repeat (5) @(posedge pclk);
            watch(4);
            check(32'(seen > 0), {31'h0, CMP_TAB[i][0]}, "send compare");
        end
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd & 32'h4, 32'h4, "send error status");
        $display("Test send compare done");
        @(posedge pclk);
        ce <= 1'b0;
        pulse(2'h2);
        check({31'h0, hold_pin}, 32'h0, "frozen hold pin");
        @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd & 32'h2, 32'h0, "frozen status");
        $display("Test freeze done");
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
